// [common/gbr_regs.svh]
// register offsets, field positions and reset values of the io bank
`ifndef GBR_REGS_SVH
`define GBR_REGS_SVH

`define GBR_ADDR_W        6
`define GBR_DATA_W        32

`define GBR_CTRL_OFS      6'h00
`define GBR_DIFF_OFS      6'h04
`define GBR_DIR_OFS       6'h08
`define GBR_STAT_OFS      6'h0C

`define GBR_CTRL_RXREG    0
`define GBR_CTRL_TXREG    1
`define GBR_CTRL_RXFALL   2
`define GBR_CTRL_TXFALL   3
`define GBR_CTRL_SRC_LSB  4
`define GBR_CTRL_CSEL_LSB 6
`define GBR_CTRL_GEAR_LSB 8
`define GBR_CTRL_BITS     12

`define GBR_STAT_USER     0
`define GBR_STAT_RST      1
`define GBR_STAT_CLKREQ   2
`define GBR_STAT_FORCED   3
`define GBR_STAT_SERDES   4
`define GBR_STAT_CLKLVL   5
`define GBR_STAT_PIN_LSB  16

`define GBR_CTRL_RST      12'h000
`define GBR_DIFF_RST      12'h000
`define GBR_DIR_RST       12'h000

`endif

// [common/gbr_pkg.sv]
// types shared by the io bank design
`default_nettype none
package gbr_pkg;

  typedef logic [5:0]  addr_t;
  typedef logic [31:0] data_t;
  typedef logic [3:0]  gear_t;

  typedef enum logic [1:0] {
    RST_CFG,
    RST_GLOBAL,
    RST_LOCAL,
    RST_SPARE
  } rst_src_t;

  typedef enum logic [1:0] {
    CLK_PLL,
    CLK_APLL,
    CLK_PIN0,
    CLK_PIN1
  } clk_sel_t;

endpackage
`default_nettype wire

// [rtl/gbr_pin_stage.sv]
// one bank pin: input filter, optional rx/tx register stage, pad drive
`timescale 1ns/1ns
`default_nettype none
module gbr_pin_stage (
  input  wire logic clk_in,          // system clock
  input  wire logic reset_in,        // system reset, active high
  input  wire logic bank_rst_in,     // selected bank reset
  input  wire logic rx_reg_en_in,    // receive stage in use
  input  wire logic tx_reg_en_in,    // transmit stage in use
  input  wire logic rx_tick_in,      // receive capture edge
  input  wire logic tx_tick_in,      // transmit launch edge
  input  wire logic diff_en_in,      // differential pair mode
  input  wire logic drive_en_in,     // pin drives outward
  input  wire logic pad_p_in,        // pad level, true side
  input  wire logic pad_n_in,        // pad level, complement side
  input  wire logic core_tx_in,      // value from core
  output logic      pad_p_out,       // pad drive, true side
  output logic      pad_n_out,       // pad drive, complement side
  output logic      pad_p_oe_n_out,  // low while true side driven
  output logic      pad_n_oe_n_out,  // low while complement driven
  output logic      core_rx_out,     // value to core
  output logic      level_out        // filtered pad level
);
  logic raw;
  logic s1_r, s2_r, s3_r, filt_r;
  logic rx_r, tx_r, tx_n_r;

  assign raw = diff_en_in ? (pad_p_in & ~pad_n_in) : pad_p_in;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      filt_r <= 1'b0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        filt_r <= s3_r;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_r <= 1'b0;
    end else if (rx_reg_en_in) begin
      if (bank_rst_in) begin
        rx_r <= 1'b0;
      end else if (rx_tick_in) begin
        rx_r <= filt_r;
      end
    end else begin
      rx_r <= filt_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_r   <= 1'b0;
      tx_n_r <= 1'b0;
    end else if (tx_reg_en_in) begin
      if (bank_rst_in) begin
        tx_r   <= 1'b0;
        tx_n_r <= 1'b0;
      end else if (tx_tick_in) begin
        tx_r   <= core_tx_in;
        tx_n_r <= diff_en_in & ~core_tx_in;
      end
    end else begin
      tx_r   <= core_tx_in;
      tx_n_r <= diff_en_in & ~core_tx_in;
    end
  end

  assign pad_p_out      = tx_r;
  assign pad_n_out      = tx_n_r;
  assign pad_p_oe_n_out = ~drive_en_in;
  assign pad_n_oe_n_out = ~(drive_en_in & diff_en_in);
  assign core_rx_out    = rx_r;
  assign level_out      = filt_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_rx_edge_capture: assert property (
    rx_reg_en_in && !bank_rst_in && !rx_tick_in
      && $stable(rx_reg_en_in) |=> $stable(rx_r))
    else $error("rx stage moved without its edge");
  chk_diff_pair_drive: assert property (
    !tx_reg_en_in && diff_en_in && $stable(diff_en_in)
      |=> tx_n_r == ~tx_r)
    else $error("differential complement not inverse");
endmodule // gbr_pin_stage
`default_nettype wire

// [rtl/gbr_bank.sv]
// io bank with registered pin stages, reset source and clock selection
`timescale 1ns/1ns
`default_nettype none
`include "gbr_regs.svh"
module gbr_bank #(
  parameter int DATA_PINS = 8,
  parameter int AUX_PINS  = 2
) (
  input  wire logic           ref_clk_in,       // 50 MHz system clock
  input  wire logic           reset_in,         // sync reset, active high
  input  wire gbr_pkg::addr_t reg_addr_in,      // register byte address
  input  wire gbr_pkg::data_t reg_wdata_in,     // register write data
  input  wire logic           reg_wr_in,        // write strobe
  input  wire logic           reg_rd_in,        // read strobe
  output gbr_pkg::data_t      reg_rdata_out,    // read data, next cycle
  input  wire logic           user_mode_in,     // config unit: user mode
  input  wire logic           glob_rst_pin_in,  // global reset track
  input  wire logic           core_rst_in,      // local reset from core
  input  wire logic           pll_clk_in,       // pll output level
  input  wire logic           apll_clk_in,      // advanced pll or bypass
  input  wire logic [11:0]    pad_p_in,         // pad levels, true side
  input  wire logic [11:0]    pad_n_in,         // pad levels, complement
  output logic      [11:0]    pad_p_out,        // pad drive, true side
  output logic      [11:0]    pad_n_out,        // pad drive, complement
  output logic      [11:0]    pad_p_oe_n_out,   // low while driven
  output logic      [11:0]    pad_n_oe_n_out,   // low while driven
  input  wire logic [11:0]    core_tx_in,       // values from core
  output logic      [11:0]    core_rx_out,      // values to core
  output logic                bank_tick_out,    // bank clock rise pulse
  output logic                bank_rst_out,     // bank reset level
  output logic                serdes_en_out,    // serializer running
  output gbr_pkg::gear_t      serial_gear_ratio_out, // serializer ratio
  output logic                serdes_tick_out   // serializer clock pulse
);
  import gbr_pkg::*;

  localparam int REG_PINS = DATA_PINS + AUX_PINS;
  localparam int NPINS    = REG_PINS + 2;

  generate
    if (DATA_PINS < 1 || AUX_PINS < 0 || NPINS != 12) begin : g_bad
      $error("bank must total twelve pins with two clock pins");
    end
  endgenerate

  // control and pin configuration registers
  logic [11:0] ctrl_r;
  logic [11:0] diff_r;
  logic [11:0] dir_r;
  data_t       rdata_r;

  logic        rx_reg_en;
  logic        tx_reg_en;
  logic        rx_fall;
  logic        tx_fall;
  rst_src_t    src_cfg;
  clk_sel_t    clk_sel;
  gear_t       gear;

  logic        any_reg;
  logic        clk_need;
  logic        forced;
  rst_src_t    src_eff;
  logic        src_rst;
  logic        bank_rst_r;

  logic [2:0]  ext_s1_r, ext_s2_r, ext_s3_r, ext_f_r;
  logic        bank_lvl;
  logic        bank_lvl_d_r;
  logic        rise;
  logic        fall;
  logic        rx_tick;
  logic        tx_tick;
  logic [11:0] pin_lvl;
  logic [11:0] drive_en;

  function automatic logic hit(input addr_t a, input addr_t ofs);
    hit = (a == ofs);
  endfunction

  assign rx_reg_en = ctrl_r[`GBR_CTRL_RXREG];
  assign tx_reg_en = ctrl_r[`GBR_CTRL_TXREG];
  assign rx_fall   = ctrl_r[`GBR_CTRL_RXFALL];
  assign tx_fall   = ctrl_r[`GBR_CTRL_TXFALL];
  assign src_cfg   = rst_src_t'(ctrl_r[`GBR_CTRL_SRC_LSB +: 2]);
  assign clk_sel   = clk_sel_t'(ctrl_r[`GBR_CTRL_CSEL_LSB +: 2]);
  assign gear      = ctrl_r[`GBR_CTRL_GEAR_LSB +: 4];

  // register writes
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl_r <= `GBR_CTRL_RST;
    end else if (reg_wr_in && hit(reg_addr_in, `GBR_CTRL_OFS)) begin
      ctrl_r <= reg_wdata_in[11:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      diff_r <= `GBR_DIFF_RST;
    end else if (reg_wr_in && hit(reg_addr_in, `GBR_DIFF_OFS)) begin
      diff_r <= reg_wdata_in[11:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      dir_r <= `GBR_DIR_RST;
    end else if (reg_wr_in && hit(reg_addr_in, `GBR_DIR_OFS)) begin
      dir_r <= reg_wdata_in[11:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (!reg_rd_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (hit(reg_addr_in, `GBR_CTRL_OFS)) begin
      rdata_r <= {20'h0_0000, ctrl_r};
    end else if (hit(reg_addr_in, `GBR_DIFF_OFS)) begin
      rdata_r <= {20'h0_0000, diff_r};
    end else if (hit(reg_addr_in, `GBR_DIR_OFS)) begin
      rdata_r <= {20'h0_0000, dir_r};
    end else if (hit(reg_addr_in, `GBR_STAT_OFS)) begin
      rdata_r <= {4'h0, pin_lvl, 10'h000, bank_lvl_d_r, serdes_en_out,
                  forced, clk_need, bank_rst_r, user_mode_in};
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_r;

  // pll, advanced pll and global reset come from other domains
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ext_s1_r <= 3'h0;
      ext_s2_r <= 3'h0;
      ext_s3_r <= 3'h0;
      ext_f_r  <= 3'h0;
    end else begin
      ext_s1_r <= {glob_rst_pin_in, apll_clk_in, pll_clk_in};
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      for (int i = 0; i < 3; i++) begin
        if (ext_s2_r[i] == ext_s3_r[i]) begin
          ext_f_r[i] <= ext_s3_r[i];
        end
      end
    end
  end

  // bank clock selection
  always_comb begin
    case (clk_sel)
      CLK_PLL:  bank_lvl = ext_f_r[0];
      CLK_APLL: bank_lvl = ext_f_r[1];
      CLK_PIN0: bank_lvl = pin_lvl[REG_PINS];
      CLK_PIN1: bank_lvl = pin_lvl[REG_PINS + 1];
      default:  bank_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bank_lvl_d_r <= 1'b0;
    end else begin
      bank_lvl_d_r <= bank_lvl;
    end
  end

  assign any_reg  = rx_reg_en | tx_reg_en;
  assign clk_need = any_reg | (gear > 4'h1);
  assign rise     = clk_need & bank_lvl & ~bank_lvl_d_r;
  assign fall     = clk_need & ~bank_lvl & bank_lvl_d_r;
  assign rx_tick  = rx_fall ? fall : rise;
  assign tx_tick  = tx_fall ? fall : rise;

  assign bank_tick_out    = rise;
  assign serdes_en_out    = gear > 4'h1;
  assign serial_gear_ratio_out = gear;
  assign serdes_tick_out  = serdes_en_out & rise;

  // reset source
  assign forced  = !any_reg && src_cfg != RST_CFG;
  assign src_eff = any_reg ? src_cfg : RST_CFG;

  always_comb begin
    case (src_eff)
      RST_CFG:    src_rst = ~user_mode_in;
      RST_GLOBAL: src_rst = ext_f_r[2];
      RST_LOCAL:  src_rst = core_rst_in;
      default:    src_rst = ~user_mode_in;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bank_rst_r <= 1'b1;
    end else begin
      bank_rst_r <= src_rst;
    end
  end

  assign bank_rst_out = bank_rst_r;

  // pins: data, then auxiliary, then the two clock pins
  generate
    for (genvar g = 0; g < NPINS; g++) begin : g_pin
      localparam bit IS_REG = (g < REG_PINS);
      assign drive_en[g] = dir_r[g];
      gbr_pin_stage u_pin (
        .clk_in         (ref_clk_in),
        .reset_in       (reset_in),
        .bank_rst_in    (bank_rst_r),
        .rx_reg_en_in   (IS_REG & rx_reg_en),
        .tx_reg_en_in   (IS_REG & tx_reg_en),
        .rx_tick_in     (rx_tick),
        .tx_tick_in     (tx_tick),
        .diff_en_in     (diff_r[g]),
        .drive_en_in    (drive_en[g]),
        .pad_p_in       (pad_p_in[g]),
        .pad_n_in       (pad_n_in[g]),
        .core_tx_in     (core_tx_in[g]),
        .pad_p_out      (pad_p_out[g]),
        .pad_n_out      (pad_n_out[g]),
        .pad_p_oe_n_out (pad_p_oe_n_out[g]),
        .pad_n_oe_n_out (pad_n_oe_n_out[g]),
        .core_rx_out    (core_rx_out[g]),
        .level_out      (pin_lvl[g])
      );
    end
  endgenerate

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence cfg_waiting;
    (src_eff == RST_CFG) && !user_mode_in;
  endsequence
  sequence cfg_entered;
    (src_eff == RST_CFG) && user_mode_in;
  endsequence

  chk_cfg_rst_hold: assert property (cfg_waiting |=> bank_rst_out)
    else $error("config reset released before user mode");
  chk_cfg_rst_free: assert property (
    cfg_entered ##1 cfg_entered |-> !bank_rst_out)
    else $error("config reset held in user mode");
  chk_unreg_src_only: assert property (
    !any_reg && user_mode_in && (core_rst_in || ext_f_r[2])
      |=> !bank_rst_out)
    else $error("unregistered bank used another reset");
  chk_local_rst_path: assert property (
    any_reg && src_cfg == RST_LOCAL && core_rst_in |=> bank_rst_out)
    else $error("local reset did not reach bank");
  chk_stage_clear: assert property (
    rx_reg_en && $stable(rx_reg_en) && bank_rst_out
      |=> core_rx_out[REG_PINS-1:0] == '0)
    else $error("rx stage not cleared under reset");
  chk_clk_need_read: assert property (
    reg_rd_in && reg_addr_in == `GBR_STAT_OFS
      |=> reg_rdata_out[`GBR_STAT_CLKREQ] == $past(clk_need))
    else $error("clock required status wrong");
  chk_serdes_gear: assert property (
    serdes_tick_out |-> gear > 4'h1 && bank_lvl && !bank_lvl_d_r)
    else $error("serializer ticked without gearing");
  chk_no_tick_idle: assert property (
    !any_reg && gear <= 4'h1 |-> !bank_tick_out)
    else $error("bank clock ran when not needed");
  chk_ctrl_readback: assert property (
    reg_rd_in && reg_addr_in == `GBR_CTRL_OFS
      |=> reg_rdata_out == {20'h0_0000, $past(ctrl_r)})
    else $error("control readback mismatch");
endmodule // gbr_bank
`default_nettype wire

// [sim/gbr_board_model.sv]
// board devices and clock sources around the io bank pins
`timescale 1ns/1ns
`default_nettype none
module gbr_board_model (
  input  wire logic        clk_in,    // system clock
  input  wire logic [3:0]  run_in,    // pll, apll, pin10, pin11 running
  input  wire logic [9:0]  data_in,   // levels the board drives
  input  wire logic [11:0] p_drv_in,  // bank drive, true side
  input  wire logic [11:0] n_drv_in,  // bank drive, complement
  input  wire logic [11:0] p_oe_n_in, // bank true side enable, low on
  input  wire logic [11:0] n_oe_n_in, // bank complement enable, low on
  output logic             pll_out,   // pll clock level
  output logic             apll_out,  // advanced pll level
  output logic      [11:0] pad_p_out, // pad level, true side
  output logic      [11:0] pad_n_out  // pad level, complement
);
  logic [1:0]  div_r = 2'h0;
  logic        ph_r  = 1'b0;
  logic [11:0] brd_p;
  always_ff @(posedge clk_in) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3) begin
      ph_r <= ~ph_r;
    end
  end
  // clocks stand still unless running
  assign pll_out  = run_in[0] & ph_r;
  assign apll_out = run_in[1] & ph_r;
  assign brd_p    = {run_in[3] & ph_r, run_in[2] & ph_r, data_in};
  // board answers differentially where the bank does not drive
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pad_p_out[i] = p_oe_n_in[i] ? brd_p[i] : p_drv_in[i];
      pad_n_out[i] = n_oe_n_in[i] ? ~brd_p[i] : n_drv_in[i];
    end
  end
endmodule // gbr_board_model
`default_nettype wire

// [sim/gbr_bank_test.sv]
// self-checking bench for the io bank
`timescale 1ns/1ns
`default_nettype none
module gbr_bank_test;
  import gbr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  addr_t       addr = 6'h00;
  data_t       wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  data_t       rdata;
  logic        um = 1'b0;
  logic        grst = 1'b0;
  logic        crst = 1'b0;
  logic        pll, apll, tick, brst, sen, stick;
  logic [11:0] pp, pn, po, pno, poe, pnoe, crx;
  logic [11:0] ctx = 12'h000;
  logic [9:0]  dat = 10'h000;
  logic [3:0]  run = 4'h0;
  gear_t       sratio;
  int          mdl[3] = '{0, 0, 0};
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [9:0]  held;
  data_t       v;

  always #10 clk = ~clk;

  gbr_bank u_gbr_bank (.ref_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .user_mode_in(um), .glob_rst_pin_in(grst),
    .core_rst_in(crst), .pll_clk_in(pll), .apll_clk_in(apll),
    .pad_p_in(pp), .pad_n_in(pn), .pad_p_out(po), .pad_n_out(pno),
    .pad_p_oe_n_out(poe), .pad_n_oe_n_out(pnoe), .core_tx_in(ctx),
    .core_rx_out(crx), .bank_tick_out(tick), .bank_rst_out(brst),
    .serdes_en_out(sen), .serial_gear_ratio_out(sratio),
    .serdes_tick_out(stick));

  gbr_board_model u_gbr_board_model (.clk_in(clk), .run_in(run),
    .data_in(dat), .p_drv_in(po), .n_drv_in(pno), .p_oe_n_in(poe),
    .n_oe_n_in(pnoe), .pll_out(pll), .apll_out(apll), .pad_p_out(pp),
    .pad_n_out(pn));

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input data_t exp, input data_t got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input addr_t a, input data_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 6'h0C && a[1:0] == 2'h0) begin
      mdl[a[3:2]] = int'(d[11:0]);
    end
  endtask

  task automatic rd_reg(input addr_t a, output data_t d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // low status bits from the model
  function automatic data_t sexp(input logic b_rst);
    logic [11:0] c;
    logic        gear;
    c = mdl[0][11:0];
    gear = c[11:8] > 4'h1;
    sexp = {27'h0, gear, ~(c[0] | c[1]) && c[5:4] != 2'h0,
            c[0] | c[1] | gear, b_rst, um};
  endfunction

  task automatic wait_tick(input logic want, input int bound);
    logic seen;
    seen = 1'b0;
    repeat (bound) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1) seen = 1'b1;
      chk("serdes tick", tick === 1'b1 && mdl[0][11:8] > 1, stick);
    end
    chk("bank tick", want, seen);
    if (want && !seen) results();
  endtask

  task automatic wait_rst(input logic want, input int bound);
    int n;
    n = 0;
    while (brst !== want && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("bank reset", want, brst);
    if (brst !== want) results();
  endtask

  initial begin
    void'($urandom(32'h852714ae));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("bank reset", 1, brst);
    chk("oe", 32'hFFF, poe);
    for (int k = 0; k < 3; k++) begin
      rd_reg(addr_t'(k * 4), v);
      chk("reg reset", mdl[k], v);
    end
    rd_reg(6'h3C, v);
    chk("unmapped", 0, v);
    for (int k = 0; k < 3; k++) wr_reg(addr_t'(k * 4), $urandom);
    wr_reg(6'h0C, 32'hFFFF_FFFF);
    wr_reg(6'h10, 32'hFFFF_FFFF);
    for (int k = 0; k < 3; k++) begin
      rd_reg(addr_t'(k * 4), v);
      chk("reg readback", mdl[k], v);
    end
    rd_reg(6'h10, v);
    chk("unmapped", 0, v);
    // unregistered bank forced to config unit reset
    wr_reg(6'h00, 32'h020);
    crst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(6'h0C, v);
    chk("status", sexp(1), v & 32'h1F);
    um <= 1'b1;
    wait_rst(0, 5);
    repeat (4) @(posedge clk);
    #1;
    chk("bank reset", 0, brst);
    rd_reg(6'h0C, v);
    chk("status", sexp(0), v & 32'h1F);
    @(posedge clk);
    crst <= 1'b0;
    // unregistered drive and receive, differential pairs
    wr_reg(6'h04, $urandom);
    wr_reg(6'h08, 32'h3FF);
    ctx <= 12'($urandom);
    repeat (3) @(posedge clk);
    #1;
    chk("pad p", ctx[9:0], po[9:0]);
    chk("pad n", ~ctx[9:0] & mdl[1][9:0], pno[9:0]);
    chk("oe", 32'h0000_0C00, poe);
    chk("oe n", {20'h0_0000, ~(12'h3FF & 12'(mdl[1]))}, pnoe);
    wr_reg(6'h08, 32'h000);
    dat <= 10'($urandom);
    repeat (10) @(posedge clk);
    #1;
    chk("core rx", dat, crx[9:0]);
    rd_reg(6'h0C, v);
    chk("pin levels", dat, v[25:16]);
    // gear ratio and clock need
    @(posedge clk);
    run <= 4'h1;
    for (int g = 0; g < 16; g++) begin
      wr_reg(6'h00, data_t'(g << 8));
      #1;
      chk("serdes en", g > 1, sen);
      chk("serial_gear_ratio", g, sratio);
      wait_tick(g > 1, 40);
    end
    // clock select among pll, advanced pll, clock pins
    for (int c = 0; c < 4; c++) begin
      wr_reg(6'h00, data_t'(1 | (c << 6)));
      run <= 4'(1 << c);
      wait_tick(1, 40);
      @(posedge clk);
      run <= 4'(1 << ((c + 1) % 4));
      // a rise already inside the filter may still land
      repeat (8) @(posedge clk);
      wait_tick(0, 40);
    end
    // registered stages under local reset
    wr_reg(6'h08, 32'h3FF);
    wr_reg(6'h00, 32'h023);
    run <= 4'h1;
    crst <= 1'b1;
    ctx <= 12'($urandom);
    repeat (4) @(posedge clk);
    #1;
    chk("bank reset", 1, brst);
    chk("pad p", 0, po[9:0]);
    chk("core rx", 0, crx[9:0]);
    @(posedge clk);
    crst <= 1'b0;
    wait_rst(0, 5);
    wait_tick(1, 40);
    repeat (2) @(posedge clk);
    #1;
    chk("pad p", ctx[9:0], po[9:0]);
    chk("core rx", ctx[9:0], crx[9:0]);
    held = ctx[9:0];
    @(posedge clk);
    run <= 4'h0;
    // let a rise already inside the filter land before new data
    repeat (8) @(posedge clk);
    ctx <= ~ctx;
    repeat (10) @(posedge clk);
    #1;
    chk("pad p", held, po[9:0]);
    // falling launch edge: data set after a rise goes out at the fall
    wr_reg(6'h00, 32'h00A);
    run <= 4'h1;
    #1;
    for (int w = 0; w < 40 && tick !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    chk("bank tick", 1, tick);
    if (tick !== 1'b1) results();
    @(posedge clk);
    ctx <= ~ctx;
    repeat (5) @(posedge clk);
    #1;
    chk("pad p fall", ctx[9:0], po[9:0]);
    // global reset track
    wr_reg(6'h00, 32'h011);
    grst <= 1'b1;
    wait_rst(1, 10);
    @(posedge clk);
    grst <= 1'b0;
    wait_rst(0, 10);
    results();
  end
endmodule // gbr_bank_test
`default_nettype wire
